// ==== hdl/serial_irq_unit.sv ====
// Interrupt unit: per-channel status, priority, summary, vectoring, cascade.
// Event inputs are synchronous pulses or levels from the channel datapaths;
// mask registers live elsewhere and arrive as plain inputs.
`default_nettype none
module serial_irq_unit (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire serial_irq_pkg::bus_req_type  busReq,
  output logic [31:0]                       readdata,
  output logic                              waitrequest,
  input  wire serial_irq_pkg::chan_evt_type events [8],
  input  wire logic [7:0][7:0]              maskZero,
  input  wire logic [7:0][7:0]              maskOne,
  input  wire logic                         ackCycleStrobe,
  input  wire logic [2:0]                   ieIn,
  output logic                              chainEnableOut,
  output logic                              chainEnableOe,
  output logic [7:0]                        vectorData,
  output logic                              vectorOe,
  output logic                              irqPinOut,
  output logic                              irqPinOe,
  output logic [7:0]                        rxIdleForce,
  output logic [7:0]                        txHalt
);
  import serial_irq_pkg::*;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_type;

  // Scan from start, optionally skipping one channel
  function automatic logic [3:0] pick_winner(input logic [7:0] pend,
                                             input logic [2:0] start,
                                             input logic       skipEn,
                                             input logic [2:0] skipCh);
    logic [3:0] res;
    logic [2:0] ch;
    res = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      ch = 3'(start + 3'(i));
      if (pend[ch] && !(skipEn && ch == skipCh)) begin
        res = {1'b1, ch};
      end
    end
    return res;
  endfunction

  bus_state_type busState_q;
  bus_state_type busState_d;
  logic [7:0]    vecBase_q;
  logic [7:0]    portCfg_q;
  logic [7:0]    statZero_q [8];
  logic [7:0]    statOne_q [8];
  logic [7:0]    pllPrev_q;
  logic [2:0]    topCh_q;
  logic [2:0]    fixedCh_q;
  logic [2:0]    rotStart_q;
  logic [7:0]    summary_q;
  logic          frozen_q;
  logic          afterVector_q;
  logic          ackPrev_q;
  logic [7:0]    vector_q;
  logic          vectorOe_q;
  logic [7:0]    readdata_q;

  wire        busActive  = busReq.read || busReq.write;
  wire        busAccept  = busActive && busState_q == BUS_DONE;
  wire [2:0]  accCh      = busReq.address[8:6];
  wire [5:0]  accIdx     = busReq.address[5:0];
  wire        lane0      = busReq.byteenable[0];
  wire        hitBase    = accIdx == VEC_BASE_IDX;
  wire        hitCfg     = accIdx == PORT_CFG_IDX;
  wire        hitZero    = accIdx == STAT_ZERO_IDX;
  wire        hitOne     = accIdx == STAT_ONE_IDX;
  wire        wrBase     = busAccept && busReq.write && hitBase && lane0;
  wire        wrCfg      = busAccept && busReq.write && hitCfg && lane0;
  wire        rdSummary  = busAccept && busReq.read && hitBase;
  wire        rdZero     = busAccept && busReq.read && hitZero;
  wire        rdOne      = busAccept && busReq.read && hitOne;

  wire        visible    = portCfg_q[VISIBLE_BIT];
  wire        rotScope   = portCfg_q[ROT_SCOPE_BIT];
  wire [2:0]  slaveId    = portCfg_q[SLAVE_ID_LSB +: 3];
  wire        daisy      = portCfg_q[CASCADE_BIT];
  wire [1:0]  stageCfg   = portCfg_q[STAGE_LSB +: 2];
  wire        rotateOn   = vecBase_q[ROTATE_BIT];
  wire        extAddr    = vecBase_q[EXT_ADDR_BIT];

  logic [7:0] pendZero [8];
  logic [7:0] pendOne [8];
  logic [7:0] chanPend;
  logic [7:0] setZero [8];
  logic [7:0] setOne [8];

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      pendZero[c] = statZero_q[c] & ~maskZero[c];
      pendOne[c]  = statOne_q[c] & ~maskOne[c];
      chanPend[c] = |pendZero[c] || |pendOne[c];
      setZero[c][7] = events[c].termChar || events[c].flushDone;
      setZero[c][6] = events[c].timeout && !maskZero[c][6];
      setZero[c][5] = events[c].parityBad && events[c].parityOn;
      setZero[c][4] = events[c].stopBitZero;
      setZero[c][3] = events[c].pllUnsynced && events[c].dpllCoding
                      && !pllPrev_q[c];
      setZero[c][2] = events[c].carrierChange;
      setZero[c][1] = events[c].rxQueueFullHit;
      setZero[c][0] = events[c].poolFull && events[c].intMode;
      setOne[c][7] = events[c].breakStart;
      setOne[c][6] = events[c].breakEnd;
      setOne[c][5] = events[c].allSent;
      setOne[c][4] = events[c].xoffSeen;
      setOne[c][3] = events[c].timerDone;
      setOne[c][2] = events[c].ctsChange;
      setOne[c][1] = events[c].xonSeen;
      setOne[c][0] = events[c].txReady;
      setZero[c] = setZero[c] & (visible ? 8'hff : ~maskZero[c]);
      setOne[c]  = setOne[c] & (visible ? 8'hff : ~maskOne[c]);
    end
  end

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      rxIdleForce[c] = events[c].pllUnsynced && events[c].dpllCoding;
      txHalt[c]      = rxIdleForce[c] && events[c].txClockDpll;
    end
  end

  wire        partial    = rotateOn && rotScope;
  wire [3:0]  scanAll    = pick_winner(chanPend, topCh_q, 1'b0, 3'h0);
  wire [3:0]  scanRest   = pick_winner(chanPend, rotStart_q, 1'b1, fixedCh_q);
  wire [3:0]  winner     = !partial ? scanAll :
                           chanPend[fixedCh_q] ? {1'b1, fixedCh_q} : scanRest;
  wire        anyPend    = winner[3];
  wire [2:0]  winCh      = winner[2:0];
  wire [7:0]  summaryLive = anyPend ? (SUMMARY_ANY | {5'h00, winCh}) : 8'h00;
  wire [7:0]  summaryOut  = frozen_q ? summary_q : summaryLive;
  wire        winFromZero = |pendZero[winCh];

  wire        slaveOk    = !daisy && ieIn == slaveId;
  wire        chainOk    = daisy && ieIn[1];
  wire        ackStart   = ackCycleStrobe && !ackPrev_q && anyPend
                           && (slaveOk || chainOk);
  wire [3:0]  vecMid     = extAddr ? vecBase_q[5:2] : {1'b0, winCh};
  wire [7:0]  vectorNext = {vecBase_q[7:6], vecMid,
                            1'b0, !winFromZero};

  assign irqPinOut = stageCfg[0] && (stageCfg[1] ? anyPend : !anyPend);
  assign irqPinOe  = stageCfg[0] ? 1'b1 : anyPend;
  assign chainEnableOut = ieIn[1] && !anyPend;
  assign chainEnableOe  = daisy;

  // One wait state: read data is captured while waitrequest is high
  assign waitrequest = busActive && busState_q == BUS_IDLE;
  assign busState_d  = (busActive && busState_q == BUS_IDLE) ? BUS_DONE
                                                             : BUS_IDLE;
  assign readdata    = {24'h000000, readdata_q};
  assign vectorData  = vector_q;
  assign vectorOe    = vectorOe_q;

  wire [7:0] readMux = !busReq.read ? 8'h00 :
                       hitBase ? summaryOut :
                       hitCfg  ? portCfg_q :
                       hitZero ? statZero_q[accCh] :
                       hitOne  ? statOne_q[accCh] : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      busState_q <= BUS_IDLE;
      readdata_q <= 8'h00;
    end else begin
      busState_q <= busState_d;
      if (waitrequest) begin
        readdata_q <= readMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      vecBase_q  <= VEC_BASE_RESET;
      topCh_q    <= 3'h0;
      fixedCh_q  <= 3'h0;
      rotStart_q <= 3'h1;
    end else if (wrBase) begin
      vecBase_q  <= busReq.writedata[7:0];
      topCh_q    <= accCh;
      fixedCh_q  <= accCh;
      rotStart_q <= 3'(accCh + 3'h1);
    end else if (ackStart && rotateOn) begin
      if (!rotScope) begin
        topCh_q <= 3'(winCh + 3'h1);
      end else if (winCh != fixedCh_q) begin
        rotStart_q <= 3'(winCh + 3'h1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      portCfg_q <= PORT_CFG_RESET;
    end else if (wrCfg) begin
      portCfg_q <= busReq.writedata[7:0];
    end
  end

  // Set wins over clear: a read clears only the bits that were read
  always_ff @(posedge clk) begin
    if (rst) begin
      pllPrev_q <= 8'h00;
      for (int c = 0; c < CHANNELS; c++) begin
        statZero_q[c] <= STATUS_RESET;
        statOne_q[c]  <= STATUS_RESET;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        pllPrev_q[c] <= events[c].pllUnsynced;
        statZero_q[c] <= (statZero_q[c]
          & ~((rdZero && accCh == 3'(c)) ? readdata_q : 8'h00)
          & ~((ackStart && winCh == 3'(c) && winFromZero)
              ? ZERO_VEC_CLEAR : 8'h00))
          | setZero[c];
        statOne_q[c] <= (statOne_q[c]
          & ~((rdOne && accCh == 3'(c)) ? readdata_q : 8'h00)
          & ~((ackStart && winCh == 3'(c) && !winFromZero)
              ? ONE_VEC_CLEAR : 8'h00))
          | setOne[c];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      summary_q     <= 8'h00;
      frozen_q      <= 1'b0;
      afterVector_q <= 1'b0;
    end else begin
      if (!frozen_q && (waitrequest || ackCycleStrobe)) begin
        summary_q <= summaryLive;
      end
      if (ackCycleStrobe || rdZero || rdOne
          || (rdSummary && afterVector_q)) begin
        frozen_q <= 1'b1;
      end else if (rdSummary) begin
        frozen_q <= 1'b0;
      end
      if (ackStart) begin
        afterVector_q <= 1'b1;
      end else if (rdSummary) begin
        afterVector_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ackPrev_q  <= 1'b0;
      vector_q   <= 8'h00;
      vectorOe_q <= 1'b0;
    end else begin
      ackPrev_q <= ackCycleStrobe;
      if (ackStart) begin
        vector_q   <= vectorNext;
        vectorOe_q <= 1'b1;
      end else if (!ackCycleStrobe) begin
        vectorOe_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== inc/serial_irq_pkg.sv ====
// Constants and carriers for the eight-channel interrupt unit.
// Assumes an Avalon-MM master with word addressing and 32-bit data.
// Functional notes
// - While anything is pending, the summary names the top channel.
// - Summary freezes on status reads, acks and first read past a vector.
// - Writing a channel's base copy makes that channel highest priority.
// - New priority applies at the end of the write, held until rewritten or rotated.
// - Vector bits 7 and 6 come from the two top vector base bits.
// - Extended addressing puts base bits 5..2 in the vector, else channel.
// - Rotation off keeps priorities fixed; on, they shift after service.
// - Full rotation makes the serviced channel lowest of all eight.
// - Partial rotation keeps one channel highest and rotates the other seven.
// - Slave cascading takes an acknowledge only on a request and id match.
// - In daisy chain the chain output drops as soon as the request rises.
// - Stage field selects open drain, push-pull low or push-pull high.
// - Reading status zero clears it; a vector clears its two block flags.
// - Masked flags may show if visible; never request, vector or summarise.
// - Termination flag sets on end character or finished receive flush.
// - Timeout flag sets only while its mask bit is clear.
// - Parity fault needs checking on; framing fault on zero stop bit.
// - Overflow on extra character when full; pool full needs interrupt mode.
// - Lost sync flags, idles receive and halts a DPLL-clocked transmitter.
// - Reading status one clears it; a vector clears transmit pool ready.
// - Break flags on a full low frame; break ended flags when it stops.
`default_nettype none
package serial_irq_pkg;
  localparam int CHANNELS = 8;
  // Register indices inside each channel's 64-word window
  localparam logic [5:0] VEC_BASE_IDX   = 6'h38;
  localparam logic [5:0] PORT_CFG_IDX   = 6'h39;
  localparam logic [5:0] STAT_ZERO_IDX  = 6'h3a;
  localparam logic [5:0] STAT_ONE_IDX   = 6'h3b;
  localparam logic [7:0] VEC_BASE_RESET = 8'h00;
  localparam logic [7:0] PORT_CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  // Vector base fields
  localparam int EXT_ADDR_BIT = 0;
  localparam int ROTATE_BIT   = 1;
  // Port configuration fields
  localparam int VISIBLE_BIT  = 7;
  localparam int ROT_SCOPE_BIT = 6;
  localparam int SLAVE_ID_LSB = 3;
  localparam int CASCADE_BIT  = 2;
  localparam int STAGE_LSB    = 0;
  // Flags cleared when their vector goes out, and the summary's pending bit
  localparam logic [7:0] ZERO_VEC_CLEAR = 8'h81;
  localparam logic [7:0] ONE_VEC_CLEAR  = 8'h01;
  localparam logic [7:0] SUMMARY_ANY    = 8'h08;

  typedef struct packed {
    logic [8:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bus_req_type;

  typedef struct packed {
    logic termChar;
    logic flushDone;
    logic timeout;
    logic parityBad;
    logic parityOn;
    logic stopBitZero;
    logic pllUnsynced;
    logic dpllCoding;
    logic txClockDpll;
    logic carrierChange;
    logic rxQueueFullHit;
    logic poolFull;
    logic intMode;
    logic breakStart;
    logic breakEnd;
    logic allSent;
    logic xoffSeen;
    logic timerDone;
    logic ctsChange;
    logic xonSeen;
    logic txReady;
  } chan_evt_type;
endpackage
`default_nettype wire

// ==== dv/serial_irq_checker.sv ====
// Checker for the interrupt unit: bus wait state, vector timing, pins.
// Bound to every serial_irq_unit instance; sees its ports only.
`default_nettype none
module serial_irq_checker (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire serial_irq_pkg::bus_req_type  busReq,
  input wire logic [31:0]                  readdata,
  input wire logic                         waitrequest,
  input wire serial_irq_pkg::chan_evt_type events [8],
  input wire logic                         ackCycleStrobe,
  input wire logic [2:0]                   ieIn,
  input wire logic                         chainEnableOut,
  input wire logic                         chainEnableOe,
  input wire logic [7:0]                   vectorData,
  input wire logic                         vectorOe,
  input wire logic                         irqPinOe,
  input wire logic [7:0]                   rxIdleForce,
  input wire logic [7:0]                   txHalt
);
  timeunit 1ns;
  timeprecision 1ns;
  import serial_irq_pkg::*;
  logic [7:0] syncLost;
  logic [7:0] dpllTx;
  wire        reqOn = busReq.read | busReq.write;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      syncLost[i] = events[i].pllUnsynced & events[i].dpllCoding;
      dpllTx[i]   = syncLost[i] & events[i].txClockDpll;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_first_wait;
    reqOn && !$past(reqOn) |-> waitrequest;
  endproperty
  a_first_wait: assert property (p_first_wait)
    else $error("request not held in its first cycle");
  property p_one_wait;
    reqOn && waitrequest |=> !waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait state");
  property p_vec_start;
    $rose(vectorOe) |-> $past(ackCycleStrobe) && !$past(ackCycleStrobe, 2);
  endproperty
  a_vec_start: assert property (p_vec_start)
    else $error("vector driven without a fresh acknowledge");
  property p_vec_hold;
    vectorOe && ackCycleStrobe |=> vectorOe && $stable(vectorData);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector changed during acknowledge");
  property p_vec_end;
    vectorOe && !ackCycleStrobe |=> !vectorOe;
  endproperty
  a_vec_end: assert property (p_vec_end)
    else $error("vector still driven after acknowledge");
  property p_chain_in;
    chainEnableOe && !ieIn[1] |-> !chainEnableOut;
  endproperty
  a_chain_in: assert property (p_chain_in)
    else $error("chain output active without chain input");
  property p_rx_idle;
    rxIdleForce == syncLost;
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("receive idle force wrong");
  property p_tx_halt;
    txHalt == dpllTx;
  endproperty
  a_tx_halt: assert property (p_tx_halt)
    else $error("transmit halt wrong");
  property p_reset;
    $past(rst) |-> !vectorOe && !chainEnableOe && !irqPinOe && readdata == 0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not quiet after reset");
endmodule
bind serial_irq_unit serial_irq_checker serial_irq_checker_i (
  .clk, .rst, .busReq, .readdata, .waitrequest, .events, .ackCycleStrobe,
  .ieIn, .chainEnableOut, .chainEnableOe, .vectorData, .vectorOe,
  .irqPinOe, .rxIdleForce, .txHalt
);
`default_nettype wire

// ==== dv/host_model.sv ====
// Host processor model: Avalon-MM master and acknowledge cycle driver.
// Assumes the clock it shares with the interrupt unit.
`default_nettype none
module host_model (
  input  wire logic                       clk,
  input  wire logic                       waitrequest,
  input  wire logic [31:0]                readdata,
  input  wire logic                       vectorOe,
  input  wire logic [7:0]                 vectorData,
  output var serial_irq_pkg::bus_req_type busReq,
  output logic                            ackCycleStrobe,
  output logic [2:0]                      ieIn
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    busReq = '0;
    ackCycleStrobe = 1'b0;
    ieIn = 3'b000;
  end
  task automatic acc(input logic [8:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    busReq.address    <= a;
    busReq.read       <= !w;
    busReq.write      <= w;
    busReq.writedata  <= {24'h0, d};
    busReq.byteenable <= 4'hf;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    busReq.read      <= 1'b0;
    busReq.write     <= 1'b0;
    // Released lines must not keep looking valid
    busReq.address   <= ~a;
    busReq.writedata <= ~{24'h0, d};
  endtask
  task automatic ack(input logic [2:0] id, output logic got,
                     output logic [7:0] v);
    @(posedge clk);
    ieIn           <= id;
    ackCycleStrobe <= 1'b1;
    repeat (2) @(posedge clk);
    got = vectorOe;
    v   = vectorData;
    ackCycleStrobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the eight-channel interrupt unit.
// Bench drives events; the host model runs bus and acknowledge traffic.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import serial_irq_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  bus_req_type  busReq;
  logic [31:0]  readdata;
  logic         waitrequest;
  chan_evt_type evt [8];
  logic         ackCycleStrobe;
  logic [2:0]   ieIn;
  logic         chainEnableOut;
  logic         chainEnableOe;
  logic [7:0]   vectorData;
  logic         vectorOe;
  logic         irqPinOut;
  logic         irqPinOe;
  logic [7:0]   rxIdleForce;
  logic [7:0]   txHalt;
  logic [7:0][7:0] maskZero = '0;
  logic [7:0][7:0] maskOne = '0;
  int           err_total = 0;
  int           check_count = 0;
  always #5 clk = ~clk;
  serial_irq_unit serial_irq_unit_i (.clk(clk), .rst(rst), .busReq(busReq),
    .readdata(readdata), .waitrequest(waitrequest), .events(evt),
    .maskZero(maskZero), .maskOne(maskOne),
    .ackCycleStrobe(ackCycleStrobe),
    .ieIn(ieIn), .chainEnableOut(chainEnableOut),
    .chainEnableOe(chainEnableOe), .vectorData(vectorData),
    .vectorOe(vectorOe), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
    .rxIdleForce(rxIdleForce), .txHalt(txHalt));
  host_model host_i (.clk(clk), .waitrequest(waitrequest),
    .readdata(readdata), .vectorOe(vectorOe), .vectorData(vectorData),
    .busReq(busReq), .ackCycleStrobe(ackCycleStrobe), .ieIn(ieIn));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host_i.acc(a, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_i.acc(a, 1'b1, d, q);
  endtask
  task automatic ak(input logic [2:0] id, input logic g, input logic [7:0] v);
    logic       got;
    logic [7:0] vec;
    host_i.ack(id, got, vec);
    chk({7'h0, got}, {7'h0, g});
    if (g) chk(vec, v);
  endtask
  task automatic pins(input logic [7:0] exp);
    @(posedge clk);
    chk({4'h0, chainEnableOe, chainEnableOut, irqPinOe, irqPinOut & irqPinOe},
        exp);
  endtask
  // Event pulses end at the next clock edge after this call
  task automatic fire();
    @(posedge clk);
    foreach (evt[i]) evt[i] <= '0;
  endtask
  task automatic t_regs();
    rd(9'h039, 8'h00);
    rd(9'h03a, 8'h00);
    rd(9'h03b, 8'h00);
    wr(9'h139, 8'h2b);
    rd(9'h079, 8'h2b);
    wr(9'h03c, 8'h5a);
    rd(9'h03c, 8'h00);
    rd(9'h038, 8'h00);
    wr(9'h039, 8'h00);
    $display("register test done");
  endtask
  task automatic t_prio();
    @(posedge clk);
    evt[2].termChar <= 1'b1;
    evt[5].termChar <= 1'b1;
    fire();
    wr(9'h178, 8'h00);
    rd(9'h038, 8'h0d);
    wr(9'h1b8, 8'h00);
    rd(9'h038, 8'h0a);
    wr(9'h0f8, 8'h00);
    rd(9'h038, 8'h0d);
    rd(9'h0ba, 8'h80);
    rd(9'h17a, 8'h80);
    rd(9'h0ba, 8'h00);
    $display("priority test done");
  endtask
  task automatic t_vec();
    wr(9'h039, 8'h28);
    wr(9'h0b8, 8'hd4);
    @(posedge clk);
    evt[2].termChar <= 1'b1;
    fire();
    ak(3'b010, 1'b0, 8'h00);
    ak(3'b101, 1'b1, 8'hc8);
    rd(9'h0ba, 8'h00);
    @(posedge clk);
    evt[6].txReady <= 1'b1;
    fire();
    wr(9'h1b8, 8'hd5);
    ak(3'b101, 1'b1, 8'hd5);
    rd(9'h1bb, 8'h00);
    $display("vector test done");
  endtask
  task automatic t_rot();
    wr(9'h039, 8'h00);
    wr(9'h038, 8'h02);
    @(posedge clk);
    evt[1].termChar <= 1'b1;
    evt[3].termChar <= 1'b1;
    fire();
    ak(3'b000, 1'b1, 8'h04);
    @(posedge clk);
    evt[1].termChar <= 1'b1;
    fire();
    ak(3'b000, 1'b1, 8'h0c);
    rd(9'h07a, 8'h80);
    wr(9'h039, 8'h40);
    wr(9'h038, 8'h02);
    @(posedge clk);
    evt[2].termChar <= 1'b1;
    evt[5].termChar <= 1'b1;
    fire();
    ak(3'b000, 1'b1, 8'h08);
    @(posedge clk);
    evt[0].termChar <= 1'b1;
    fire();
    ak(3'b000, 1'b1, 8'h00);
    rd(9'h17a, 8'h80);
    $display("rotation test done");
  endtask
  task automatic t_chain();
    wr(9'h039, 8'h04);
    host_i.ieIn <= 3'b010;
    pins(8'h0c);
    @(posedge clk);
    evt[4].termChar <= 1'b1;
    fire();
    pins(8'h0a);
    wr(9'h039, 8'h05);
    pins(8'h0a);
    wr(9'h039, 8'h07);
    pins(8'h0b);
    ak(3'b000, 1'b0, 8'h00);
    ak(3'b010, 1'b1, 8'h10);
    pins(8'h0e);
    wr(9'h039, 8'h00);
    $display("chain test done");
  endtask
  task automatic t_err();
    @(posedge clk);
    evt[1].parityBad <= 1'b1;
    evt[1].stopBitZero <= 1'b1;
    fire();
    rd(9'h07a, 8'h10);
    @(posedge clk);
    evt[1].parityBad <= 1'b1;
    evt[1].parityOn <= 1'b1;
    evt[1].timeout <= 1'b1;
    evt[1].rxQueueFullHit <= 1'b1;
    evt[1].poolFull <= 1'b1;
    evt[1].breakStart <= 1'b1;
    evt[1].breakEnd <= 1'b1;
    fire();
    rd(9'h07a, 8'h62);
    rd(9'h07b, 8'hc0);
    @(posedge clk);
    evt[1].flushDone <= 1'b1;
    evt[1].poolFull <= 1'b1;
    evt[1].intMode <= 1'b1;
    fire();
    rd(9'h07a, 8'h81);
    @(posedge clk);
    evt[7].pllUnsynced <= 1'b1;
    evt[7].dpllCoding <= 1'b1;
    evt[7].txClockDpll <= 1'b1;
    @(posedge clk);
    chk(rxIdleForce & txHalt, 8'h80);
    rd(9'h1fa, 8'h08);
    fire();
    $display("status test done");
  endtask
  // Masked flags show only when visible and never raise a request
  task automatic t_mask();
    wr(9'h039, 8'h80);
    @(posedge clk);
    maskZero[3] <= 8'hc0;
    maskOne[3] <= 8'h01;
    evt[3].termChar <= 1'b1;
    evt[3].timeout <= 1'b1;
    evt[3].txReady <= 1'b1;
    fire();
    pins(8'h04);
    ak(3'b000, 1'b0, 8'h00);
    rd(9'h0fa, 8'h80);
    rd(9'h0fb, 8'h01);
    wr(9'h039, 8'h00);
    @(posedge clk);
    evt[3].termChar <= 1'b1;
    fire();
    rd(9'h0fa, 8'h00);
    @(posedge clk);
    maskZero <= '0;
    maskOne <= '0;
    wr(9'h038, 8'h00);
    $display("mask test done");
  endtask
  // Two plain summary reads first, so the freeze state is known
  task automatic t_freeze();
    logic [7:0] q;
    host_i.acc(9'h038, 1'b0, 8'h00, q);
    host_i.acc(9'h038, 1'b0, 8'h00, q);
    @(posedge clk);
    evt[5].termChar <= 1'b1;
    fire();
    rd(9'h0fa, 8'h00);
    @(posedge clk);
    evt[2].termChar <= 1'b1;
    fire();
    wr(9'h0b8, 8'h00);
    rd(9'h038, 8'h0d);
    rd(9'h038, 8'h0a);
    ak(3'b000, 1'b1, 8'h08);
    rd(9'h038, 8'h0a);
    rd(9'h038, 8'h0a);
    rd(9'h038, 8'h0d);
    rd(9'h17a, 8'h80);
    $display("freeze test done");
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    foreach (evt[i]) evt[i] = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_prio();
    t_vec();
    t_rot();
    t_chain();
    t_err();
    t_mask();
    t_freeze();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
